// ### logic/sotp_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - enter command switches accesses into OTP
// - exit command leaves OTP mode
// - status and security writes rejected in OTP
// - locked OTP refuses page program; reads, exit and other commands still accepted
// - main array writes blocked in OTP
// - security register readable anytime, continuously
// - bit 0 shows factory lock
// - lock-down bit sets once, then frozen
// - security write needs no write enable
// - security write needs byte-aligned deselect
// - locked OTP data never updated again
// - serial region 000-00F, customer 010-1FF
module sotp_ctrl (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                factory_locked,
   input  wire logic                spi_clk,
   input  wire logic                spi_cs_n,
   input  wire logic                spi_di,
   output logic                     spi_do,
   output logic                     spi_do_oe,
   output sotp_pkg::sotp_stat_t     status,
   output logic                     main_wr_block,
   output logic                     otp_serial_hit,
   output logic                     otp_customer_hit,
   output logic                     wsec_reject
);
   // ---------------- link domain (spi_clk) ----------------
   // cs high acts as the frame reset; link clock only runs inside frames
   logic [7:0]            sh_r;
   logic [2:0]            bitc_r;
   logic [7:0]            cmd_r;
   logic [1:0]            addr_cnt_r;
   logic [23:0]           addr_r;
   sotp_pkg::sotp_phase_t ph_r;
   logic [7:0]            wsec_byte_r;
   logic                  wsec_got_r;
   logic                  evt_tgl_r;
   logic [1:0]            evt_kind_r;
   logic [7:0]            rd_byte_r;
   logic [7:0]            sec_q_r;
   logic                  otp_q_r;
   logic                  lock_q_r;
   logic                  wen_r;
   logic [7:0]            otp_mem [sotp_pkg::OTP_BYTES];
   logic [7:0]            byte_in;
   logic [7:0]            sec_val;
   logic [23:0]           addr_last_r;
   logic [5:0]            rd_idx;
   logic [7:0]            rd_src;
   logic                  otp_prog_ok;
   logic                  end_aligned;
   logic                  end_enter;
   logic                  end_exit;
   logic                  end_lock;
   logic [1:0]            end_kind;
   // limitation: the array has no reset, unwritten cells read unknown

   assign byte_in = {sh_r[6:0], spi_di};

   // main-domain state
   logic                  otp_mode_r;
   logic                  lock_r;
   logic                  fact_r;
   logic [7:0]            sec_reg;
   assign sec_reg = {6'h00, lock_r | fact_r, fact_r};

   // simple level crossings into link domain
   logic [2:0] to_link_s1_r;
   logic [2:0] to_link_s2_r;
   always_ff @(posedge spi_clk) begin
      to_link_s1_r <= {otp_mode_r, lock_r, fact_r};
      to_link_s2_r <= to_link_s1_r;
   end
   // levels only change between frames, so two flops suffice
   always_comb begin
      otp_q_r  = to_link_s2_r[2];
      // factory lock freezes the area just like the customer bit
      lock_q_r = to_link_s2_r[1] | to_link_s2_r[0];
      sec_val  = {6'h00, to_link_s2_r[1] | to_link_s2_r[0],
                  to_link_s2_r[0]};
   end

   // next read byte: the array in mode, erased pattern outside it
   always_comb begin
      if (ph_r == sotp_pkg::PH_ADDR)
         rd_idx = byte_in[5:0];
      else
         rd_idx = addr_r[5:0] + 6'h01;
      if (otp_q_r)
         rd_src = otp_mem[rd_idx];
      else
         rd_src = sotp_pkg::OTP_BLANK;
   end

   always_ff @(posedge spi_clk or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         sh_r        <= 8'h00;
         bitc_r      <= 3'h0;
         cmd_r       <= 8'h00;
         addr_cnt_r  <= 2'h0;
         addr_r      <= 24'h00_0000;
         ph_r        <= sotp_pkg::PH_CMD;
         wsec_byte_r <= 8'h00;
         wsec_got_r  <= 1'b0;
         rd_byte_r   <= 8'h00;
      end else begin
         sh_r   <= byte_in;
         bitc_r <= bitc_r + 3'h1;
         if (bitc_r == 3'h7) begin
            case (ph_r)
               sotp_pkg::PH_CMD: begin
                  cmd_r <= byte_in;
                  case (byte_in)
                     sotp_pkg::CMD_READ,
                     sotp_pkg::CMD_PAGE_PROG:
                        ph_r <= sotp_pkg::PH_ADDR;
                     sotp_pkg::CMD_WR_SEC:
                        ph_r <= sotp_pkg::PH_WSEC;
                     // status writes have no effect here
                     sotp_pkg::CMD_WR_SR1,
                     sotp_pkg::CMD_WR_SR2:
                        ph_r <= sotp_pkg::PH_IGN;
                     sotp_pkg::CMD_RD_SEC: begin
                        ph_r      <= sotp_pkg::PH_DATA;
                        rd_byte_r <= sec_val;
                     end
                     default:
                        ph_r <= sotp_pkg::PH_IGN;
                  endcase
               end
               sotp_pkg::PH_ADDR: begin
                  addr_r     <= {addr_r[15:0], byte_in};
                  addr_cnt_r <= addr_cnt_r + 2'h1;
                  if (addr_cnt_r == 2'h2) begin
                     ph_r      <= sotp_pkg::PH_DATA;
                     rd_byte_r <= rd_src;
                  end
               end
               sotp_pkg::PH_DATA: begin
                  addr_r <= addr_r + 24'h00_0001;
                  if (cmd_r == sotp_pkg::CMD_RD_SEC)
                     rd_byte_r <= sec_val;
                  else
                     rd_byte_r <= rd_src;
               end
               sotp_pkg::PH_WSEC: begin
                  wsec_byte_r <= byte_in;
                  wsec_got_r  <= 1'b1;
               end
               default: ph_r <= sotp_pkg::PH_IGN;
            endcase
         end
      end
   end

   always_comb begin
      otp_prog_ok = cmd_r == sotp_pkg::CMD_PAGE_PROG && otp_q_r
                    && !lock_q_r && wen_r
                    && addr_r[23:9] == 15'h0000;
   end

   // OTP array write: one byte per data beat of a program in OTP mode
   always_ff @(posedge spi_clk) begin
      if (!spi_cs_n && ph_r == sotp_pkg::PH_DATA && bitc_r == 3'h7
          && otp_prog_ok)
         // once-only is carried by the lock bit, not per cell
         otp_mem[addr_r[5:0]] <= byte_in;
   end

   // last address kept past deselect for the region decode
   always_ff @(posedge spi_clk) begin
      if (!spi_cs_n && ph_r == sotp_pkg::PH_ADDR && bitc_r == 3'h7
          && addr_cnt_r == 2'h2)
         addr_last_r <= {addr_r[15:0], byte_in};
      else if (!spi_cs_n && ph_r == sotp_pkg::PH_CMD && bitc_r == 3'h7
               && byte_in == sotp_pkg::CMD_ENTER_OTP)
         addr_last_r <= 24'h00_0000;
   end

   // write enable latch seen in link domain, set by WREN and kept through program
   always_ff @(posedge spi_clk) begin
      if (!spi_cs_n && ph_r == sotp_pkg::PH_CMD && bitc_r == 3'h7) begin
         if (byte_in == sotp_pkg::CMD_WREN)
            wen_r <= 1'b1;
         else if (byte_in == sotp_pkg::CMD_PAGE_PROG)
            wen_r <= wen_r;
         else
            wen_r <= wen_r;
      end
   end

   // data out on falling edge
   always_ff @(negedge spi_clk or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         spi_do    <= 1'b0;
         spi_do_oe <= 1'b0;
      end else begin
         spi_do    <= rd_byte_r[3'h7 - bitc_r];
         spi_do_oe <= (ph_r == sotp_pkg::PH_DATA);
      end
   end

   // frame-end classification, read at cs rise before the frame clears
   // deselect must fall on byte boundary
   always_comb begin
      end_aligned = (bitc_r == 3'h0);
      end_enter   = ph_r == sotp_pkg::PH_IGN && end_aligned
                    && cmd_r == sotp_pkg::CMD_ENTER_OTP;
      end_exit    = ph_r == sotp_pkg::PH_IGN && end_aligned
                    && cmd_r == sotp_pkg::CMD_EXIT_OTP;
      end_lock    = ph_r == sotp_pkg::PH_WSEC && wsec_got_r && end_aligned
                    && wsec_byte_r[sotp_pkg::SEC_LOCKDN_BIT];
      if (end_enter)
         end_kind = 2'h1;
      else if (end_exit)
         end_kind = 2'h2;
      else if (end_lock)
         end_kind = 2'h3;
      else
         end_kind = 2'h0;
   end

   // frame-end event: a toggle, so no pulse is lost across domains
   always_ff @(posedge spi_cs_n or negedge rst_n) begin
      if (!rst_n) begin
         evt_tgl_r  <= 1'b0;
         evt_kind_r <= 2'h0;
      end else begin
         evt_tgl_r  <= ~evt_tgl_r;
         evt_kind_r <= end_kind;
      end
   end

   // ---------------- main domain (clk) ----------------
   logic [2:0] tgl_sync_r;
   logic [1:0] kind_s1_r;
   logic [1:0] kind_s2_r;
   logic [1:0] fact_sync_r;
   logic [1:0] csn_sync_r;
   logic       evt;

   // kind reaches kind_s2_r in the same cycle the toggle edge raises evt
   always_ff @(posedge clk) begin
      tgl_sync_r <= {tgl_sync_r[1:0], evt_tgl_r};
      kind_s1_r  <= evt_kind_r;
      kind_s2_r  <= kind_s1_r;
   end

   // strap and frame select pass through two flops each from the pins
   always_ff @(posedge clk) begin
      fact_sync_r <= {fact_sync_r[0], factory_locked};
      csn_sync_r  <= {csn_sync_r[0], spi_cs_n};
   end
   assign evt = tgl_sync_r[2] ^ tgl_sync_r[1];

   always_ff @(posedge clk) begin
      if (!rst_n)
         fact_r <= 1'b0;
      else
         fact_r <= fact_sync_r[1];
   end

   always_ff @(posedge clk) begin
      if (!rst_n)
         otp_mode_r <= 1'b0;
      else if (evt && kind_s2_r == 2'h1)
         otp_mode_r <= 1'b1;
      else if (evt && kind_s2_r == 2'h2)
         otp_mode_r <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!rst_n)
         lock_r <= 1'b0;
      else if (evt && kind_s2_r == 2'h3 && !otp_mode_r)
         lock_r <= 1'b1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n)
         wsec_reject <= 1'b0;
      else
         wsec_reject <= evt && kind_s2_r == 2'h3 && otp_mode_r;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status <= '0;
      end else begin
         status.otp_mode      <= otp_mode_r;
         status.factory_lock  <= sec_reg[sotp_pkg::SEC_FACTORY_BIT];
         status.customer_lock <= sec_reg[sotp_pkg::SEC_LOCKDN_BIT];
      end
   end

   // main array write blocked
   // a flag only: program in mode never reaches the main array
   always_ff @(posedge clk) begin
      if (!rst_n)
         main_wr_block <= 1'b0;
      else
         main_wr_block <= otp_mode_r;
   end

   // region decode of the last address taken
   // the address is only read while deselected, so it stands still
   logic otp_space;
   always_comb begin
      otp_space = otp_mode_r && csn_sync_r[1]
                  && addr_last_r[23:9] == 15'h0000;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         otp_serial_hit   <= 1'b0;
         otp_customer_hit <= 1'b0;
      end else begin
         otp_serial_hit   <= otp_space &&
            addr_last_r[8:0] <= sotp_pkg::OTP_SERIAL_LAST;
         otp_customer_hit <= otp_space &&
            addr_last_r[8:0] >  sotp_pkg::OTP_SERIAL_LAST &&
            addr_last_r[8:0] <= sotp_pkg::OTP_LAST;
      end
   end
endmodule

// ### logic/sotp_pkg.sv
package sotp_pkg;
   localparam logic [7:0] CMD_ENTER_OTP   = 8'hB1;
   localparam logic [7:0] CMD_EXIT_OTP    = 8'hC1;
   localparam logic [7:0] CMD_RD_SEC      = 8'h2B;
   localparam logic [7:0] CMD_WR_SEC      = 8'h2F;
   localparam logic [7:0] CMD_WR_SR1      = 8'h01;
   localparam logic [7:0] CMD_WR_SR2      = 8'h31;
   localparam logic [7:0] CMD_WREN        = 8'h06;
   localparam logic [7:0] CMD_READ        = 8'h03;
   localparam logic [7:0] CMD_FAST_READ   = 8'h0B;
   localparam logic [7:0] CMD_PAGE_PROG   = 8'h02;
   localparam logic [7:0] CMD_SECT_ERASE  = 8'h20;
   localparam int         SEC_FACTORY_BIT = 0;
   localparam int         SEC_LOCKDN_BIT  = 1;
   localparam logic [8:0] OTP_SERIAL_LAST = 9'h00F;
   localparam logic [8:0] OTP_LAST        = 9'h1FF;
   localparam int         OTP_BYTES       = 64;
   localparam logic [7:0] OTP_BLANK       = 8'hFF;
   localparam logic [7:0] SEC_RESET       = 8'h00;

   typedef enum logic [2:0] {
      PH_CMD  = 3'b000,
      PH_ADDR = 3'b001,
      PH_DATA = 3'b010,
      PH_WSEC = 3'b011,
      PH_IGN  = 3'b100
   } sotp_phase_t;

   typedef struct packed {
      logic       otp_mode;
      logic       factory_lock;
      logic       customer_lock;
   } sotp_stat_t;

   typedef struct packed {
      logic       valid;
      logic       wr;
      logic [8:0] addr;
      logic [7:0] data;
   } sotp_req_t;
endpackage

// ### tb/sotp_ctrl_checker.sv
`timescale 1ns/1ps
module sotp_ctrl_checker (
   input wire logic                 clk,
   input wire logic                 rst_n,
   input wire logic                 factory_locked,
   input wire logic                 spi_cs_n,
   input wire sotp_pkg::sotp_stat_t status,
   input wire logic                 main_wr_block,
   input wire logic                 otp_serial_hit,
   input wire logic                 otp_customer_hit,
   input wire logic                 wsec_reject
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // one cycle of skew between mode and block is tolerated
   a_block_in_mode: assert property (
      status.otp_mode && $past(status.otp_mode) |-> main_wr_block)
      else $error("main array writable in otp mode");
   a_block_released: assert property (
      !status.otp_mode && !$past(status.otp_mode) |-> !main_wr_block)
      else $error("main array still blocked");
   a_lock_sticky: assert property (
      $past(status.customer_lock) |-> status.customer_lock)
      else $error("lock-down bit cleared");
   a_factory_follows: assert property (
      $stable(factory_locked)[*8] |-> status.factory_lock == factory_locked)
      else $error("factory lock not reflected");
   a_reject_pulse: assert property (
      wsec_reject |=> !wsec_reject)
      else $error("reject longer than a cycle");
   a_reject_in_mode: assert property (
      wsec_reject |-> status.otp_mode)
      else $error("reject outside otp mode");
   a_reject_keeps_lock: assert property (
      wsec_reject && !status.customer_lock |=> (!status.customer_lock)[*8])
      else $error("refused write changed lock");
   a_hits_exclusive: assert property (
      !(otp_serial_hit && otp_customer_hit))
      else $error("both otp regions hit");
   a_mode_on_deselect: assert property (
      $rose(status.otp_mode) |-> spi_cs_n)
      else $error("mode changed inside a frame");
   a_lock_outside_mode: assert property (
      $rose(status.customer_lock) |-> !status.otp_mode)
      else $error("lock set while in otp mode");

   cover property (wsec_reject);
   cover property ($rose(status.customer_lock));
   cover property (otp_serial_hit);
   cover property (otp_customer_hit);
endmodule

bind sotp_ctrl sotp_ctrl_checker u_chk (.clk(clk), .rst_n(rst_n),
   .factory_locked(factory_locked), .spi_cs_n(spi_cs_n), .status(status),
   .main_wr_block(main_wr_block), .otp_serial_hit(otp_serial_hit),
   .otp_customer_hit(otp_customer_hit), .wsec_reject(wsec_reject));

// ### tb/sotp_ctrl_test.sv
`timescale 1ns/1ps
module sotp_ctrl_test;
   logic                 clk, rst_n, factory_locked, wsec_reject;
   logic                 spi_clk, spi_cs_n, spi_di, spi_do, spi_do_oe;
   logic                 main_wr_block, otp_serial_hit, otp_customer_hit;
   sotp_pkg::sotp_stat_t status;
   logic [7:0]           rx, d, seen, rej;
   logic [7:0]           exp_q[$];
   int                   bad_count, check_count;
   event                 seen_ev;

   sotp_ctrl u_sotp_ctrl (.clk, .rst_n, .factory_locked, .spi_clk, .spi_cs_n,
      .spi_di, .spi_do, .spi_do_oe, .status, .main_wr_block, .otp_serial_hit,
      .otp_customer_hit, .wsec_reject);
   sotp_host u_sotp_host (.spi_clk, .spi_cs_n, .spi_di, .spi_do);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
      if (!rst_n)
         rej <= 8'h00;
      else if (wsec_reject === 1'b1)
         rej <= rej + 8'h01;

   task automatic check(input logic [7:0] got, input logic [7:0] want);
      check_count++;
      if (got !== want) begin
         bad_count++;
         $display("ERROR %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic note(input logic [7:0] want);
      exp_q.push_back(want);
   endtask
   task automatic look(input logic [7:0] v);
      seen = v;
      ->seen_ev;
      #1;
   endtask
   task automatic run(input int nb, input logic [7:0] op,
                      input logic [31:0] rest);
      u_sotp_host.frame(nb, {op, rest}, rx);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial forever begin
      @(seen_ev);
      check(seen, exp_q.pop_front());
   end
   initial begin
      #150000;
      bad_count++;
      stop_test();
   end

   initial begin
      rst_n          = 1'b1;
      factory_locked = 1'b0;
      #1 rst_n       = 1'b0;
      void'($urandom(20538));
      d = 8'($urandom);
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      note(8'h00); look({5'h00, status});
      run(16, sotp_pkg::CMD_RD_SEC, 32'h0000_0000);
      note(8'h00); look(rx & 8'h03);
      run(8, sotp_pkg::CMD_ENTER_OTP, 32'h0000_0000);
      note(8'h04); look({5'h00, status});
      note(8'h01); look({7'h00, main_wr_block});
      run(16, sotp_pkg::CMD_WR_SEC, 32'h0200_0000);
      note(8'h01); look(rej);
      note(8'h04); look({5'h00, status});
      run(8, sotp_pkg::CMD_WREN, 32'h0000_0000);
      run(40, sotp_pkg::CMD_PAGE_PROG, {24'h00_0010, d});
      note(8'h01); look({7'h00, otp_customer_hit});
      run(40, sotp_pkg::CMD_READ, 32'h0000_0500);
      note(8'h01); look({7'h00, otp_serial_hit});
      run(40, sotp_pkg::CMD_READ, 32'h0000_1000);
      note(d); look(rx);
      run(8, sotp_pkg::CMD_EXIT_OTP, 32'h0000_0000);
      note(8'h00); look({5'h00, status});
      note(8'h00); look({7'h00, main_wr_block});
      // cut four bits short of a whole byte
      run(12, sotp_pkg::CMD_WR_SEC, 32'h0200_0000);
      note(8'h00); look({5'h00, status});
      run(16, sotp_pkg::CMD_WR_SEC, 32'h0200_0000);
      note(8'h01); look({5'h00, status});
      run(24, sotp_pkg::CMD_RD_SEC, 32'h0000_0000);
      note(8'h02); look(rx & 8'h03);
      run(16, sotp_pkg::CMD_WR_SEC, 32'h0000_0000);
      note(8'h01); look({5'h00, status});
      run(8, sotp_pkg::CMD_ENTER_OTP, 32'h0000_0000);
      run(8, sotp_pkg::CMD_WREN, 32'h0000_0000);
      run(40, sotp_pkg::CMD_PAGE_PROG, {24'h00_0010, ~d});
      run(40, sotp_pkg::CMD_READ, 32'h0000_1000);
      note(d); look(rx);
      run(8, sotp_pkg::CMD_EXIT_OTP, 32'h0000_0000);
      @(posedge clk);
      factory_locked <= 1'b1;
      repeat (8) @(posedge clk);
      run(16, sotp_pkg::CMD_RD_SEC, 32'h0000_0000);
      note(8'h03); look(rx & 8'h03);
      #20;
      stop_test();
   end
endmodule

// ### tb/sotp_host.sv
`timescale 1ns/1ps
module sotp_host (
   output logic      spi_clk,
   output logic      spi_cs_n,
   output logic      spi_di,
   input  wire logic spi_do
);
   initial begin
      spi_clk  = 1'b0;
      spi_cs_n = 1'b1;
      spi_di   = 1'b0;
   end

   // link clock runs only inside a frame, 80 ns period
   task automatic frame(input int nb, input logic [39:0] tx,
                        output logic [7:0] rx);
      #3;
      spi_cs_n = 1'b0;
      for (int i = 0; i < nb; i++) begin
         spi_di = tx[39-i];
         #40 spi_clk = 1'b1;
         rx = {rx[6:0], spi_do};
         #40 spi_clk = 1'b0;
      end
      #40 spi_cs_n = 1'b1;
      // released line must not keep the last bit
      spi_di = ~spi_di;
      #100;
   endtask
endmodule
